// >>> sramc_ctrl.sv
// Host controller for a 32K x 8 asynchronous static memory.
// Assumes the data pins are joined to one bus by the surroundings, using
// sram_dq_oe_o; user requests come from logic on clk_i.
//
// How it works
// - Strobe low only while chip select is low
// - Data timed to the edge ending write
// - Address held through the whole write
// - Strobe width honours the output-enable-low minimum
// - Strobe width honours the output-enable-high minimum
// - Data driven well before the write ends
// - Data released only after the write end
// - Address changes only after write end
// - Write strobe high through every read
// - Reads keep select and output enable low
// - Address valid no later than select falls
`timescale 1ns/10ps
`default_nettype none

module sramc_ctrl #(
  parameter bit FAST_GRADE = 1'b1 // Selects the timing set of the part
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // User request port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [sramc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sramc_pkg::DATA_W-1:0] wdata_i,
  output logic ready_o,
  output logic [sramc_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic wdone_o,
  // Memory pins
  output logic [sramc_pkg::ADDR_W-1:0] sram_addr_o,
  output logic sram_ce_n_o,
  output logic sram_oe_n_o,
  output logic sram_we_n_o,
  output logic [sramc_pkg::DATA_W-1:0] sram_dq_o,
  output logic sram_dq_oe_o,
  input wire logic [sramc_pkg::DATA_W-1:0] sram_dq_i
);

  // ---------------------------------------------------------------
  // Grade dependent counts
  // ---------------------------------------------------------------
  // Chosen at elaboration, so the slow grade costs no logic
  localparam logic [sramc_pkg::CNT_W-1:0] WR_PULSE_CYC = FAST_GRADE ?
    sramc_pkg::WR_PULSE_FAST_CYC : sramc_pkg::WR_PULSE_SLOW_CYC;
  localparam logic [sramc_pkg::CNT_W-1:0] RD_ACC_CYC = FAST_GRADE ?
    sramc_pkg::RD_ACC_FAST_CYC : sramc_pkg::RD_ACC_SLOW_CYC;
  localparam logic [sramc_pkg::CNT_W-1:0] TURN_CYC = FAST_GRADE ?
    sramc_pkg::TURN_FAST_CYC : sramc_pkg::TURN_SLOW_CYC;
  localparam logic [sramc_pkg::CNT_W-1:0] CYCLE_CYC = FAST_GRADE ?
    sramc_pkg::CYCLE_FAST_CYC : sramc_pkg::CYCLE_SLOW_CYC;

  // ---------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------
  sramc_pkg::sramc_state_type state;      // Current phase
  sramc_pkg::sramc_state_type next_state; // Phase after this edge
  logic timer_zero;  // Current phase has run its length
  logic timer_load;  // Start timing a new phase
  logic [sramc_pkg::CNT_W-1:0] timer_count; // Length of that phase
  logic [sramc_pkg::DATA_W-1:0] dq_sync;  // Data pins after two flops

  wire st_idle = (state == sramc_pkg::ST_IDLE);
  wire st_wset = (state == sramc_pkg::ST_WSET);
  wire st_wpulse = (state == sramc_pkg::ST_WPULSE);
  wire st_whold = (state == sramc_pkg::ST_WHOLD);
  wire st_racc = (state == sramc_pkg::ST_RACC);
  wire st_turn = (state == sramc_pkg::ST_TURN);

  // Request accepted only from idle, which is what ready_o shows
  wire go = st_idle & req_i;
  wire go_write = go & we_i;
  wire go_read = go & ~we_i;
  wire read_end = st_racc & timer_zero;

  // ---------------------------------------------------------------
  // Next phase
  // ---------------------------------------------------------------
  // Write: set-up, strobe, hold; read: access, bus turnaround
  always_comb begin
    next_state = state;
    unique case (state)
      sramc_pkg::ST_IDLE: begin
        if (go_write) begin
          next_state = sramc_pkg::ST_WSET;
        end else if (go_read) begin
          next_state = sramc_pkg::ST_RACC;
        end
      end
      sramc_pkg::ST_WSET: begin
        next_state = sramc_pkg::ST_WPULSE;
      end
      sramc_pkg::ST_WPULSE: begin
        if (timer_zero) begin
          next_state = sramc_pkg::ST_WHOLD;
        end
      end
      sramc_pkg::ST_WHOLD: begin
        next_state = sramc_pkg::ST_IDLE;
      end
      sramc_pkg::ST_RACC: begin
        if (timer_zero) begin
          next_state = sramc_pkg::ST_TURN;
        end
      end
      sramc_pkg::ST_TURN: begin
        if (timer_zero) begin
          next_state = sramc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sramc_pkg::ST_IDLE; // Illegal code recovers to idle
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Phase timer
  // ---------------------------------------------------------------
  // Loaded on the edge that enters a timed phase
  assign timer_load = go_read | st_wset | read_end;
  assign timer_count = st_wset ? WR_PULSE_CYC :
                       st_racc ? TURN_CYC : RD_ACC_CYC;

  sramc_timer #(
    .WIDTH(sramc_pkg::CNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .zero_o(timer_zero)
  );

  // ---------------------------------------------------------------
  // Data input synchroniser
  // ---------------------------------------------------------------
  // Read data pass two flops; the access phase is stretched to match
  sramc_sync #(
    .WIDTH(sramc_pkg::DATA_W)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(sram_dq_i),
    .sync_o(dq_sync)
  );

  // ---------------------------------------------------------------
  // Next pin and user values
  // ---------------------------------------------------------------
  wire ns_wset = (next_state == sramc_pkg::ST_WSET);
  wire ns_wpulse = (next_state == sramc_pkg::ST_WPULSE);
  wire ns_whold = (next_state == sramc_pkg::ST_WHOLD);
  wire ns_racc = (next_state == sramc_pkg::ST_RACC);

  // Address moves only with the select edge of a new access
  wire [sramc_pkg::ADDR_W-1:0] next_addr = go ? addr_i : sram_addr_o;
  // Select and strobe rise together, so one edge ends the write
  wire next_ce_n = ~(ns_wset | ns_wpulse | ns_racc);
  wire next_we_n = ~ns_wpulse;
  // Output enable stays high in writes so the memory never drives back
  wire next_oe_n = ~ns_racc;
  wire next_dq_oe = ns_wset | ns_wpulse | ns_whold;
  wire [sramc_pkg::DATA_W-1:0] next_dq = go_write ? wdata_i : sram_dq_o;
  wire [sramc_pkg::DATA_W-1:0] next_rdata = read_end ? dq_sync : rdata_o;
  wire next_ready = (next_state == sramc_pkg::ST_IDLE);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // All pins idle-safe in reset: deselected, strobes high, bus released
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= sramc_pkg::ST_IDLE;
      sram_addr_o <= '0;
      sram_ce_n_o <= 1'b1;
      sram_oe_n_o <= 1'b1;
      sram_we_n_o <= 1'b1;
      sram_dq_o <= '0;
      sram_dq_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      sram_addr_o <= next_addr;
      sram_ce_n_o <= next_ce_n;
      sram_oe_n_o <= next_oe_n;
      sram_we_n_o <= next_we_n;
      sram_dq_o <= next_dq;
      sram_dq_oe_o <= next_dq_oe;
    end
  end

  // User side answers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ready_o <= 1'b0;
      rdata_o <= '0;
      rvalid_o <= 1'b0;
      wdone_o <= 1'b0;
    end else begin
      ready_o <= next_ready;
      rdata_o <= next_rdata;
      rvalid_o <= read_end;
      wdone_o <= st_whold;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [sramc_pkg::CNT_W-1:0] wlow_age; // Cycles strobe has been low
  logic [sramc_pkg::CNT_W-1:0] addr_age; // Cycles since address moved

  // Saturating helpers; limit keeps the plus-one below overflow
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wlow_age <= '0;
      addr_age <= 4'hE;
    end else begin
      wlow_age <= (!sram_we_n_o && wlow_age != 4'hE) ? wlow_age + 1'b1 :
                  (!sram_we_n_o) ? wlow_age : 4'h0;
      addr_age <= (next_addr != sram_addr_o) ? 4'h0 :
                  (addr_age != 4'hE) ? addr_age + 1'b1 : addr_age;
    end
  end

  property p_we_needs_ce;
    !sram_we_n_o |-> !sram_ce_n_o;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce)
    else $error("write strobe low without chip select");

  property p_addr_held;
    !sram_ce_n_o && $past(!sram_ce_n_o) |-> $stable(sram_addr_o);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("address moved while selected");

  property p_pulse_oe_high;
    !sram_we_n_o && next_we_n |-> (wlow_age + 1'b1) >= WR_PULSE_CYC;
  endproperty
  a_pulse_oe_high: assert property (p_pulse_oe_high)
    else $error("write strobe too short");

  property p_pulse_oe_low;
    !sram_we_n_o && next_we_n && !sram_oe_n_o |->
      (wlow_age + 1'b1) >= 4'(sramc_pkg::cycles_min(
      sramc_pkg::WRITE_PULSE_MIN_OE_LOW_NS));
  endproperty
  a_pulse_oe_low: assert property (p_pulse_oe_low)
    else $error("write strobe too short with output enable low");

  property p_data_setup;
    $fell(sram_we_n_o) |-> sram_dq_oe_o && $past(sram_dq_oe_o) &&
      $stable(sram_dq_o);
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("write data not set up before strobe");

  property p_write_end;
    $rose(sram_we_n_o) |-> $rose(sram_ce_n_o) && sram_dq_oe_o &&
      $stable(sram_dq_o) ##1 !sram_dq_oe_o;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write end edge or data hold wrong");

  property p_read_we_high;
    !sram_oe_n_o |-> sram_we_n_o && !sram_dq_oe_o;
  endproperty
  a_read_we_high: assert property (p_read_we_high)
    else $error("strobe or bus driven during read");

  property p_read_length;
    $fell(sram_oe_n_o) |-> (!sram_oe_n_o && !sram_ce_n_o)[*4] ##1 sram_oe_n_o
      ##[0:2] rvalid_o;
  endproperty
  a_read_length: assert property (p_read_length)
    else $error("read strobes not held for the access");

  property p_addr_with_ce;
    $changed(sram_addr_o) |-> $fell(sram_ce_n_o);
  endproperty
  a_addr_with_ce: assert property (p_addr_with_ce)
    else $error("address changed outside select fall");

  property p_cycle_time;
    next_addr != sram_addr_o |-> (addr_age + 1'b1) >= CYCLE_CYC;
  endproperty
  a_cycle_time: assert property (p_cycle_time)
    else $error("access started before cycle time");

  c_write: cover property ($rose(wdone_o));
  c_read: cover property ($rose(rvalid_o));
  c_read_then_write: cover property (rvalid_o ##[1:4] $fell(sram_we_n_o));

endmodule : sramc_ctrl
`default_nettype wire

// >>> sramc_pkg.sv
// Constants shared by the asynchronous static memory host controller.
// Assumes a 100 MHz controller clock; all pin timing is rounded to cycles.

package sramc_pkg;

  // ---------------------------------------------------------------
  // Geometry and clock
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;        // 32K words
  localparam int DATA_W = 8;         // Byte-wide data bus
  localparam int CNT_W = 4;          // Width of the phase timer
  localparam int SYNC_STAGES = 2;    // Flops on the data pins before use
  localparam int CLK_PERIOD_NS = 10; // 100 MHz

  // ---------------------------------------------------------------
  // Pin timing in ns, fast grade then slow grade
  // ---------------------------------------------------------------
  localparam int RC_FAST_NS = 10;   // Read cycle time
  localparam int RC_SLOW_NS = 12;
  localparam int AA_FAST_NS = 10;   // Address access time
  localparam int AA_SLOW_NS = 12;
  localparam int WC_FAST_NS = 10;   // Write cycle time
  localparam int WC_SLOW_NS = 12;
  localparam int AW_FAST_NS = 9;    // Address setup to write end
  localparam int AW_SLOW_NS = 10;
  localparam int HZOE_FAST_NS = 5;  // Output float after output enable
  localparam int HZOE_SLOW_NS = 6;
  localparam int SD_NS = 7;         // Data setup to write end
  localparam int WRITE_PULSE_MIN_OE_LOW_NS = 9;
  localparam int WRITE_PULSE_MIN_OE_HIGH_NS = 8;

  // Least time to whole cycles: round up, never below one
  function automatic int cycles_min(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cycles_min

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction : max3

  // ---------------------------------------------------------------
  // Cycle counts per grade
  // ---------------------------------------------------------------
  // Strobe width covers both output enable cases, address and data setup
  localparam logic [CNT_W-1:0] WR_PULSE_FAST_CYC = CNT_W'(max3(
    cycles_min(WRITE_PULSE_MIN_OE_LOW_NS), cycles_min(AW_FAST_NS),
    cycles_min(SD_NS)));
  localparam logic [CNT_W-1:0] WR_PULSE_SLOW_CYC = CNT_W'(max3(
    cycles_min(WRITE_PULSE_MIN_OE_LOW_NS), cycles_min(AW_SLOW_NS),
    cycles_min(SD_NS)));
  // Read strobes stay on for access time plus the input synchroniser, plus
  // one cycle so the first flop samples after the access time, not on it
  localparam logic [CNT_W-1:0] RD_ACC_FAST_CYC =
    CNT_W'(cycles_min(AA_FAST_NS) + SYNC_STAGES + 1);
  localparam logic [CNT_W-1:0] RD_ACC_SLOW_CYC =
    CNT_W'(cycles_min(AA_SLOW_NS) + SYNC_STAGES + 1);
  localparam logic [CNT_W-1:0] TURN_FAST_CYC = CNT_W'(cycles_min(HZOE_FAST_NS));
  localparam logic [CNT_W-1:0] TURN_SLOW_CYC = CNT_W'(cycles_min(HZOE_SLOW_NS));
  localparam logic [CNT_W-1:0] CYCLE_FAST_CYC =
    CNT_W'((RC_FAST_NS > WC_FAST_NS) ? cycles_min(RC_FAST_NS) : cycles_min(WC_FAST_NS));
  localparam logic [CNT_W-1:0] CYCLE_SLOW_CYC =
    CNT_W'((RC_SLOW_NS > WC_SLOW_NS) ? cycles_min(RC_SLOW_NS) : cycles_min(WC_SLOW_NS));

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_WSET   = 6'h02,
    ST_WPULSE = 6'h04,
    ST_WHOLD  = 6'h08,
    ST_RACC   = 6'h10,
    ST_TURN   = 6'h20
  } sramc_state_type;

endpackage : sramc_pkg

// >>> sramc_sync.sv
// Two-flop synchroniser for the memory data pins.
// Assumes the inputs are asynchronous to clk_i; no logic reads stage one.
`timescale 1ns/10ps
`default_nettype none

module sramc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------
  // Per-bit double flop
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta; // First stage, read only by the second
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          meta <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta <= async_i[g];
          sync_o[g] <= meta;
        end
      end
    end
  endgenerate

endmodule : sramc_sync
`default_nettype wire

// >>> sramc_timer.sv
// Down counter that times each strobe phase of the memory controller.
// Assumes a load count of at least one; zero_o is high once it has run out.
`timescale 1ns/10ps
`default_nettype none

module sramc_timer #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic zero_o
);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] cnt; // Cycles left in the phase, minus one
  logic [WIDTH-1:0] next_cnt;

  // Load takes priority; otherwise count down and stop at zero
  assign next_cnt = load_i ? WIDTH'(count_i - 1'b1) :
                    (cnt != '0) ? WIDTH'(cnt - 1'b1) : cnt;
  assign zero_o = (cnt == '0);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : sramc_timer
`default_nettype wire

// >>> sramc_mem_model.sv
// Behavioural model of the 32K x 8 asynchronous static memory.
// Assumes host data arrives as value plus enable; returns the resolved bus level.
`timescale 1ns/10ps
`default_nettype none

module sramc_mem_model #(
  parameter int ACC_NS = sramc_pkg::AA_FAST_NS // Access time after address or select
) (
  input wire logic [sramc_pkg::ADDR_W-1:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [sramc_pkg::DATA_W-1:0] host_dq_i,
  input wire logic host_dq_oe_i,
  output logic [sramc_pkg::DATA_W-1:0] bus_o,
  output logic drive_o
);
  // ---------------------------------------------------------------
  // Storage and write path
  // ---------------------------------------------------------------
  logic [sramc_pkg::DATA_W-1:0] mem [0:(1<<sramc_pkg::ADDR_W)-1]; // Array
  logic [sramc_pkg::DATA_W-1:0] wr_buf; // Data seen during overlap
  logic [sramc_pkg::ADDR_W-1:0] wr_addr; // Address seen during overlap
  logic [sramc_pkg::DATA_W-1:0] rd_val; // Data the array offers
  logic [sramc_pkg::DATA_W-1:0] last_val; // Last value anyone drove
  logic in_write; // Select and strobe overlap
  logic acc_ok = 1'b0; // Access time has run out
  realtime stamp = 0.0; // Last address or select change

  assign in_write = !ce_n_i && !we_n_i;
  // Follow the bus through the overlap, so whichever strobe ends it sets the data
  always @(in_write, addr_i, bus_o) begin
    if (in_write) begin
      wr_buf = bus_o;
      wr_addr = addr_i;
    end
  end
  // Commit when the overlap closes
  always @(negedge in_write) begin
    mem[wr_addr] = wr_buf;
  end

  // ---------------------------------------------------------------
  // Read path and bus resolution
  // ---------------------------------------------------------------
  // Any change restarts the access timer; old data is not trusted meanwhile
  always @(addr_i, ce_n_i, oe_n_i) begin
    stamp = $realtime;
    acc_ok = 1'b0;
  end
  always #1 acc_ok = ($realtime - stamp) >= ACC_NS;
  // Drive only in the read state, float as soon as the strobe falls
  assign drive_o = !ce_n_i && !oe_n_i && we_n_i;
  assign rd_val = acc_ok ? mem[addr_i] : ~mem[addr_i];
  // Remember the last driven value so a floating bus shows its inverse
  always @(host_dq_oe_i, host_dq_i, drive_o, rd_val) begin
    if (host_dq_oe_i) begin
      last_val = host_dq_i;
    end else if (drive_o) begin
      last_val = rd_val;
    end
  end
  // Contention gives unknown, which no read comparison will accept
  assign bus_o = (host_dq_oe_i && drive_o) ? {sramc_pkg::DATA_W{1'bx}} :
                 host_dq_oe_i ? host_dq_i : drive_o ? rd_val : ~last_val;
endmodule : sramc_mem_model
`default_nettype wire

// >>> async_sram_cycle_timing_test.sv
// Self-checking bench for the static memory host controller, fast grade.
// Assumes the memory model in its own file; all timing checks sample pins.
`timescale 1ns/10ps
`default_nettype none

module async_sram_cycle_timing_test;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic [14:0] addr_i = 15'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic ready_o, rvalid_o, wdone_o, ce_n, oe_n, we_n, dq_oe, mem_drive;
  logic [7:0] rdata_o, dq_o, dq_bus;
  logic [14:0] sram_addr;
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk_i = ~clk_i; // 100 MHz

  sramc_ctrl #(.FAST_GRADE(1'b1)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .we_i(we_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .wdone_o(wdone_o), .sram_addr_o(sram_addr),
    .sram_ce_n_o(ce_n), .sram_oe_n_o(oe_n), .sram_we_n_o(we_n),
    .sram_dq_o(dq_o), .sram_dq_oe_o(dq_oe), .sram_dq_i(dq_bus));
  sramc_mem_model mem_u (
    .addr_i(sram_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .host_dq_i(dq_o), .host_dq_oe_i(dq_oe), .bus_o(dq_bus), .drive_o(mem_drive));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Pin monitor; counts are cycles of a 10 ns clock
  logic [14:0] p_addr = 15'h0000;
  logic [7:0] p_dq = 8'h00;
  logic p_ce = 1'b1;
  logic p_we = 1'b1;
  int a_cnt = 0, w_cnt = 0, d_cnt = 0, gap = 100;
  always @(posedge clk_i) begin
    #2;
    if (sys_rst_i === 1'b0) begin
      check("strobe_outside_select", !we_n && ce_n, 1'b0);
      check("strobe_in_read", !oe_n && !we_n, 1'b0);
      check("oe_outside_select", !oe_n && ce_n, 1'b0);
      if (sram_addr !== p_addr) check("addr_move_selected", p_ce, 1'b1);
      if (p_we === 1'b0 && we_n === 1'b1) begin
        check("addr_setup", a_cnt * 10 >= sramc_pkg::AW_FAST_NS, 1'b1);
        check("pulse_width", w_cnt * 10 >= sramc_pkg::WRITE_PULSE_MIN_OE_LOW_NS, 1'b1);
        check("data_setup", d_cnt * 10 >= sramc_pkg::SD_NS, 1'b1);
        check("data_held_at_end", dq_oe, 1'b1);
      end
      if (p_ce === 1'b1 && ce_n === 1'b0) begin
        check("cycle_spacing", gap * 10 >= sramc_pkg::WC_FAST_NS, 1'b1);
        gap = 0;
      end
    end
    // Stability counters for the next write end
    a_cnt = (sram_addr !== p_addr) ? 1 : a_cnt + 1;
    w_cnt = (we_n === 1'b0) ? w_cnt + 1 : 0;
    d_cnt = (dq_oe !== 1'b1) ? 0 : (dq_o === p_dq) ? d_cnt + 1 : 1;
    gap++;
    p_addr = sram_addr;
    p_dq = dq_o;
    p_ce = ce_n;
    p_we = we_n;
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  // Waits for ready, holds the request over one edge; returns in cycle 0
  task automatic issue(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("ready_wait", ready_o, 1'b1);
    req_i = 1'b1;
    we_i = w;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
  endtask : issue

  task automatic write_chk(input logic [14:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
    check("wr_addr", sram_addr, a);
    check("wr_data", dq_o, d);
    repeat (2) begin
      @(posedge clk_i);
      #1;
      check("wdone_early", wdone_o, 1'b0);
    end
    @(posedge clk_i);
    #1;
    check("wdone", wdone_o, 1'b1);
    check("ready_after_write", ready_o, 1'b1);
  endtask : write_chk

  task automatic read_chk(input logic [14:0] a, input logic [7:0] exp);
    issue(1'b0, a, 8'h00);
    repeat (3) begin
      @(posedge clk_i);
      #1;
      check("rvalid_early", rvalid_o, 1'b0);
    end
    @(posedge clk_i);
    #1;
    check("rvalid", rvalid_o, 1'b1);
    check("rdata", rdata_o, exp);
    check("ready_in_turn", ready_o, 1'b0);
    @(posedge clk_i);
    #1;
    check("ready_after_read", ready_o, 1'b1);
  endtask : read_chk

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic reset_chk();
    sys_rst_i = 1'b1;
    req_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    check("reset_pins", {ce_n, oe_n, we_n, dq_oe, ready_o, rvalid_o, wdone_o}, 7'b1110000);
    check("reset_addr", sram_addr, 15'h0000);
    check("reset_rdata", rdata_o, 8'h00);
    sys_rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    check("ready_after_reset", ready_o, 1'b1);
    $display("done: reset");
  endtask : reset_chk

  // Boundary addresses back to back, one overwritten
  task automatic table_chk();
    logic [14:0] ta [5];
    logic [7:0] td [5];
    ta = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA, 15'h5555};
    td = '{8'hA5, 8'h5A, 8'hFF, 8'h00, 8'hC3};
    for (int i = 0; i < 5; i++) write_chk(ta[i], td[i]);
    for (int i = 0; i < 4; i++) read_chk(ta[i], (i == 2) ? 8'hC3 : td[i]);
    $display("done: table");
  endtask : table_chk

  // Request held while busy must wait for ready, then carry the new fields
  task automatic refused_chk();
    int pulses;
    pulses = 0;
    issue(1'b1, 15'h0123, 8'h11);
    @(posedge clk_i);
    #1;
    req_i = 1'b1;
    addr_i = 15'h0456;
    wdata_i = 8'h22;
    repeat (8) begin
      if (wdone_o === 1'b1) pulses++;
      if (ready_o === 1'b1 && req_i === 1'b1) begin
        @(posedge clk_i);
        #1;
        req_i = 1'b0;
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
    check("wdone_pulses", pulses, 2);
    read_chk(15'h0123, 8'h11);
    read_chk(15'h0456, 8'h22);
    $display("done: refused");
  endtask : refused_chk

  // Reset in mid-read; the array keeps its contents
  task automatic midreset_chk();
    issue(1'b0, 15'h7FFF, 8'h00);
    @(posedge clk_i);
    #1;
    reset_chk();
    read_chk(15'h7FFF, 8'h5A);
    write_chk(15'h1234, 8'h69);
    $display("done: midreset");
  endtask : midreset_chk

  initial begin
    reset_chk();
    table_chk();
    refused_chk();
    midreset_chk();
    summarize();
  end

  // Whole run is about ninety cycles; cut off well beyond that
  initial begin
    #50000;
    mismatches++;
    $display("[FAIL] watchdog expected finish seen timeout");
    summarize();
  end
endmodule : async_sram_cycle_timing_test
`default_nettype wire
